// file: core/rps_consts.svh
// constants of the resonant protection and settings controller
// assumes a 200 MHz system clock and comparator levels from the analog front end
// Contract
// - cut gate early when current nears zero
// - zero-current cut never raises a protection
// - overcurrent cuts active gate, switching continues
// - five overcurrent cycles latch and disable companion
// - overtemperature latches and disables companion
// - overpower timer expiry latches or restarts
// - clamp commanded swing to power capability
// - a setting disables the overpower timer
// - measure resistor codes before switching starts
// - four burst frequencies, largest resistor lowest
// - first code selects power and overpower options
// - settings below minimum inhibit start-up forever
// - lowest valid code gives infinite overpower timer
// - overpower action is timed restart or latch
// - second code selects mode transition levels
// - burst level from second code and frequency
// - after measuring, power-good pin driven high
// - entering operation drives power-good pin low
// - pin high on boost drop or timer end
// - power-good ends ahead of overpower expiry
// - protection stops switching, pin driven low
// - latch holds until mains disconnection signalled
// - companion disabled by pulling boost pin low
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH
`define RPS_CMR_LO_MV     (-100)
`define RPS_CMR_HI_MV     100
`define RPS_OCP_CYCLES    3'h5
`define RPS_CLK_NS        5
`define RPS_MS_NS         1000000
`define RPS_CYC_PER_MS    (`RPS_MS_NS / `RPS_CLK_NS)
`define RPS_OPP_LONG_MS   11'h0c8
`define RPS_OPP_SHORT_MS  11'h032
`define RPS_PG_LONG_MS    11'h0be
`define RPS_PG_SHORT_MS   11'h02d
`define RPS_RESTART_MS    11'h3e8
`define RPS_ADR_CTRL      2'h0
`define RPS_ADR_STATUS    2'h1
`define RPS_ADR_SETTINGS  2'h2
`define RPS_ADR_OPPCNT    2'h3
`define RPS_CTRL_RST      1'h1
`endif

// file: core/rps_pkg.sv
// types of the resonant protection and settings controller
// assumes rps_consts.svh carries the numbers
package rps_pkg;
   typedef enum logic [2:0] {
      RPS_IDLE, RPS_MEASURE, RPS_WAIT_BOOST, RPS_RUN,
      RPS_PROT_LATCH, RPS_PROT_RESTART, RPS_NOSTART
   } rps_state_e;
   typedef struct packed {
      logic cap200;    // power capability 200 percent, else 150
      logic lvl175;    // timer start level 175 percent, else 125
      logic opp_inf;   // overpower timer disabled
      logic long_t;    // 200 ms timer, else 50 ms
      logic latched;   // latch on expiry, else timed restart
   } rps_set1_s;
endpackage : rps_pkg

// file: core/rps_ctrl.sv
// protection, settings decode and power-good logic of the half-bridge controller
// assumes comparator and resistor-code inputs from pins, gate requests from
// the regulation loop on i_sys_clk, and a classic Wishbone master
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`include "rps_consts.svh"
module rps_ctrl #(
   parameter int          P_CYC_PER_MS = `RPS_CYC_PER_MS,  // cycles per ms tick
   parameter logic [11:0] P_LIM150     = 12'h600,          // swing limit 150 percent
   parameter logic [11:0] P_LIM200     = 12'h800           // swing limit 200 percent
) (
   input  wire logic        i_sys_clk,        // system clock
   input  wire logic        i_nrst,           // async reset, active low
   input  wire logic        i_wb_cyc,         // bus cycle
   input  wire logic        i_wb_stb,         // bus strobe
   input  wire logic        i_wb_we,          // bus write
   input  wire logic [3:0]  i_wb_adr,         // byte address
   input  wire logic [31:0] i_wb_dat,         // write data
   input  wire logic [3:0]  i_wb_sel,         // byte lanes
   output logic [31:0]      o_wb_dat,         // read data
   output logic             o_wb_ack,         // bus acknowledge
   input  wire logic        i_hs_req,         // regulation asks high side on
   input  wire logic        i_ls_req,         // regulation asks low side on
   input  wire logic [11:0] i_swing_cmd,      // commanded cap-voltage swing
   input  wire logic        i_cur_near_zero,  // current within capacitive band
   input  wire logic        i_ocp,            // current above overcurrent level
   input  wire logic        i_otp,            // overtemperature detector
   input  wire logic        i_opp_over,       // swing above overpower level
   input  wire logic        i_boost_start,    // boost sense above start level
   input  wire logic        i_boost_det,      // boost sense above detect level
   input  wire logic        i_mains_reset,    // mains disconnection signalled
   input  wire logic        i_meas_done,      // resistor codes are valid
   input  wire logic [3:0]  i_set1_code,      // first settings resistor code
   input  wire logic [2:0]  i_set2_code,      // second settings resistor code
   input  wire logic [1:0]  i_bfreq_code,     // burst frequency resistor code
   output logic             o_hs_gate,        // high side gate
   output logic             o_ls_gate,        // low side gate
   output logic             o_boost_pulldown, // pull boost sense pin low
   output logic             o_pg_out,         // settings/power-good pin level
   output logic             o_pg_oe,          // settings/power-good pin enable
   output logic [11:0]      o_swing_lim,      // clamped swing command
   output logic [1:0]       o_burst_freq,     // 0=200 Hz .. 3=1600 Hz
   output logic [1:0]       o_hp_lp_level,    // 25/37.5/50/62.5 percent
   output logic [7:0]       o_burst_level,    // burst entry, half percent
   output logic             o_opp_lvl175      // timer start level select
);
   ////////////////////////////////////////////////////////////////////
   // decode functions
   function automatic rps_pkg::rps_set1_s dec_set1(input logic [3:0] c);
      rps_pkg::rps_set1_s s;
      logic [3:0]         k;
      k = c - 4'h2;
      s.cap200  = ~k[1];
      s.lvl175  = ~k[1];
      s.long_t  = ~k[0];
      s.latched = k[2];
      s.opp_inf = 1'b0;
      if (c == 4'h1) begin
         s = '{cap200: 1'b1, lvl175: 1'b1, opp_inf: 1'b1, long_t: 1'b1, latched: 1'b0};
      end
      return s;
   endfunction : dec_set1
   // burst entry level in half percent, by second code and frequency
   function automatic logic [7:0] burst_lvl(input logic [2:0] c, input logic [1:0] f);
      logic [31:0] row;
      case (c)
         3'h0:    row = 32'h12121212;
         3'h1:    row = 32'h18181818;
         3'h2:    row = 32'h14121212;
         3'h3:    row = 32'h1a181818;
         3'h4:    row = 32'h18161412;
         3'h5:    row = 32'h221e1a18;
         3'h6:    row = 32'h1c181412;
         default: row = 32'h28231e18;
      endcase
      return row[{f, 3'h0} +: 8];
   endfunction : burst_lvl
   ////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for all pin inputs
   localparam int SW = 17;
   logic [SW-1:0] sy1_r;
   logic [SW-1:0] sy2_r;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sy1_r <= '0;
         sy2_r <= '0;
      end else begin
         sy1_r <= {i_set1_code, i_set2_code, i_bfreq_code, i_cur_near_zero, i_ocp,
                   i_otp, i_opp_over, i_boost_start, i_boost_det, i_mains_reset,
                   i_meas_done};
         sy2_r <= sy1_r;
      end
   end
   wire logic [3:0] set1_s  = sy2_r[16:13];
   wire logic [2:0] set2_s  = sy2_r[12:10];
   wire logic [1:0] bf_s    = sy2_r[9:8];
   wire logic       zc_s    = sy2_r[7];
   wire logic       ocp_s   = sy2_r[6];
   wire logic       otp_s   = sy2_r[5];
   wire logic       oppo_s  = sy2_r[4];
   wire logic       bst_s   = sy2_r[3];
   wire logic       bdet_s  = sy2_r[2];
   wire logic       mains_s = sy2_r[1];
   wire logic       meas_s  = sy2_r[0];
   ////////////////////////////////////////////////////////////////////
   // millisecond tick divider
   logic [31:0] div_r;
   logic        ms_tick_r;
   wire logic   div_end = (div_r == 32'(P_CYC_PER_MS - 1));
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_r     <= '0;
         ms_tick_r <= 1'b0;
      end else begin
         div_r     <= div_end ? '0 : div_r + 32'h1;
         ms_tick_r <= div_end;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // wishbone slave: ctrl, status, settings, overpower count
   logic        enable_r;
   logic        ack_r;
   logic [31:0] rdat_r;
   logic [31:0] rdat_nxt;
   wire logic       wb_req = i_wb_cyc & i_wb_stb & ~ack_r;
   wire logic [1:0] wb_idx = i_wb_adr[3:2];
   ////////////////////////////////////////////////////////////////////
   // stored settings and state
   rps_pkg::rps_state_e state_r;
   rps_pkg::rps_state_e state_nxt;
   rps_pkg::rps_set1_s  set1_r;
   logic [2:0]  set2_r;
   logic [1:0]  bf_r;
   logic [10:0] opp_cnt_r;
   logic [10:0] rst_cnt_r;
   logic [2:0]  ocp_cnt_r;
   logic        ocp_seen_r;
   logic        hs_cut_r;
   logic        ls_cut_r;
   logic        ls_req_d_r;
   logic        lat_ocp_r;
   logic        lat_otp_r;
   logic        lat_opp_r;
   // overpower timer end and power-good end by setting
   wire logic [10:0] opp_end = set1_r.long_t ? `RPS_OPP_LONG_MS : `RPS_OPP_SHORT_MS;
   wire logic [10:0] pg_end  = set1_r.long_t ? `RPS_PG_LONG_MS : `RPS_PG_SHORT_MS;
   wire logic        run     = (state_r == rps_pkg::RPS_RUN);
   // cycle end is the fall of the low side request
   wire logic cyc_end  = ls_req_d_r & ~i_ls_req;
   wire logic ocp_any  = ocp_seen_r | (ocp_s & (i_hs_req | i_ls_req));
   wire logic ocp_trip = run & cyc_end & ocp_any & (ocp_cnt_r == `RPS_OCP_CYCLES - 3'h1);
   wire logic opp_hit  = run & ~set1_r.opp_inf & (opp_cnt_r >= opp_end);
   wire logic otp_trip = run & otp_s;
   // state transitions
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rps_pkg::RPS_IDLE:
            if (enable_r) begin
               state_nxt = rps_pkg::RPS_MEASURE;
            end
         rps_pkg::RPS_MEASURE:
            if (meas_s) begin
               state_nxt = (set1_s == 4'h0) ? rps_pkg::RPS_NOSTART
                                            : rps_pkg::RPS_WAIT_BOOST;
            end
         rps_pkg::RPS_WAIT_BOOST:
            if (bst_s) begin
               state_nxt = rps_pkg::RPS_RUN;
            end
         rps_pkg::RPS_RUN:
            if (otp_trip || ocp_trip) begin
               state_nxt = rps_pkg::RPS_PROT_LATCH;
            end else if (opp_hit) begin
               state_nxt = set1_r.latched ? rps_pkg::RPS_PROT_LATCH
                                          : rps_pkg::RPS_PROT_RESTART;
            end
         rps_pkg::RPS_PROT_LATCH:
            if (mains_s) begin
               state_nxt = rps_pkg::RPS_IDLE;
            end
         rps_pkg::RPS_PROT_RESTART:
            if (rst_cnt_r >= `RPS_RESTART_MS) begin
               state_nxt = rps_pkg::RPS_WAIT_BOOST;
            end
         rps_pkg::RPS_NOSTART:
            state_nxt = rps_pkg::RPS_NOSTART;
         default:
            state_nxt = rps_pkg::RPS_IDLE;
      endcase
   end
   // output decode from next state, so pins change with the state
   wire logic run_n   = (state_nxt == rps_pkg::RPS_RUN);
   wire logic prot_n  = (state_nxt == rps_pkg::RPS_PROT_LATCH) ||
                        (state_nxt == rps_pkg::RPS_PROT_RESTART);
   wire logic pull_n  = (state_nxt == rps_pkg::RPS_IDLE) ||
                        (state_nxt == rps_pkg::RPS_MEASURE) ||
                        (state_nxt == rps_pkg::RPS_NOSTART) || prot_n;
   wire logic cut_now = zc_s | ocp_s;
   wire logic hs_nxt  = run_n & i_hs_req & ~hs_cut_r & ~cut_now;
   wire logic ls_nxt  = run_n & i_ls_req & ~ls_cut_r & ~cut_now;
   wire logic pg_wait = (state_nxt == rps_pkg::RPS_WAIT_BOOST);
   wire logic pg_run  = run_n & (~bdet_s | (~set1_r.opp_inf & (opp_cnt_r >= pg_end)));
   wire logic pg_nxt  = pg_wait | pg_run;
   wire logic oe_nxt  = (state_nxt != rps_pkg::RPS_MEASURE) &&
                        (state_nxt != rps_pkg::RPS_IDLE);
   wire logic [11:0] lim = set1_r.cap200 ? P_LIM200 : P_LIM150;
   // register read mux
   always_comb begin
      rdat_nxt = 32'h0;
      case (wb_idx)
         `RPS_ADR_CTRL:     rdat_nxt = {31'h0, enable_r};
         `RPS_ADR_STATUS:   rdat_nxt = {22'h0, ocp_cnt_r, lat_opp_r, lat_otp_r,
                                        lat_ocp_r, 1'b0, state_r};
         `RPS_ADR_SETTINGS: rdat_nxt = {19'h0, set1_r, set2_r, bf_r, set1_s == 4'h0,
                                        2'h0};
         `RPS_ADR_OPPCNT:   rdat_nxt = {21'h0, opp_cnt_r};
         default:           rdat_nxt = 32'h0;
      endcase
   end
   // bus registers
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         enable_r <= `RPS_CTRL_RST;
         ack_r    <= 1'b0;
         rdat_r   <= '0;
      end else begin
         ack_r  <= wb_req;
         rdat_r <= rdat_nxt;
         if (wb_req && i_wb_we && i_wb_sel[0] && wb_idx == `RPS_ADR_CTRL) begin
            enable_r <= i_wb_dat[0];
         end
      end
   end
   // state, stored settings and protection flags
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r   <= rps_pkg::RPS_IDLE;
         set1_r    <= '0;
         set2_r    <= '0;
         bf_r      <= '0;
         lat_ocp_r <= 1'b0;
         lat_otp_r <= 1'b0;
         lat_opp_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == rps_pkg::RPS_MEASURE && meas_s) begin
            set1_r <= dec_set1(set1_s);
            set2_r <= set2_s;
            bf_r   <= bf_s;
         end
         if (state_r == rps_pkg::RPS_IDLE && enable_r) begin
            lat_ocp_r <= 1'b0;
            lat_otp_r <= 1'b0;
            lat_opp_r <= 1'b0;
         end else begin
            lat_ocp_r <= lat_ocp_r | ocp_trip;
            lat_otp_r <= lat_otp_r | otp_trip;
            lat_opp_r <= lat_opp_r | opp_hit;
         end
      end
   end
   // overpower timer and restart wait, in ms ticks
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         opp_cnt_r <= '0;
         rst_cnt_r <= '0;
      end else begin
         if (!run || !oppo_s || set1_r.opp_inf) begin
            opp_cnt_r <= '0;
         end else if (ms_tick_r && opp_cnt_r != 11'h7ff) begin
            opp_cnt_r <= opp_cnt_r + 11'h1;
         end
         if (state_r != rps_pkg::RPS_PROT_RESTART) begin
            rst_cnt_r <= '0;
         end else if (ms_tick_r) begin
            rst_cnt_r <= rst_cnt_r + 11'h1;
         end
      end
   end
   // per-gate cut flags and consecutive overcurrent count
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hs_cut_r   <= 1'b0;
         ls_cut_r   <= 1'b0;
         ls_req_d_r <= 1'b0;
         ocp_seen_r <= 1'b0;
         ocp_cnt_r  <= '0;
      end else begin
         hs_cut_r   <= i_hs_req & (hs_cut_r | cut_now);
         ls_cut_r   <= i_ls_req & (ls_cut_r | cut_now);
         ls_req_d_r <= i_ls_req;
         if (!run) begin
            ocp_seen_r <= 1'b0;
            ocp_cnt_r  <= '0;
         end else if (cyc_end) begin
            ocp_seen_r <= 1'b0;
            ocp_cnt_r  <= ocp_any ? ocp_cnt_r + 3'h1 : 3'h0;
         end else begin
            ocp_seen_r <= ocp_any;
         end
      end
   end
   // registered outputs
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hs_gate        <= 1'b0;
         o_ls_gate        <= 1'b0;
         o_boost_pulldown <= 1'b1;
         o_pg_out         <= 1'b0;
         o_pg_oe          <= 1'b0;
         o_swing_lim      <= '0;
         o_burst_freq     <= '0;
         o_hp_lp_level    <= '0;
         o_burst_level    <= '0;
         o_opp_lvl175     <= 1'b0;
      end else begin
         o_hs_gate        <= hs_nxt;
         o_ls_gate        <= ls_nxt;
         o_boost_pulldown <= pull_n;
         o_pg_out         <= pg_nxt;
         o_pg_oe          <= oe_nxt;
         o_swing_lim      <= (i_swing_cmd > lim) ? lim : i_swing_cmd;
         o_burst_freq     <= bf_r;
         o_hp_lp_level    <= set2_r[2:1];
         o_burst_level    <= burst_lvl(set2_r, bf_r);
         o_opp_lvl175     <= set1_r.lvl175;
      end
   end
   assign o_wb_ack = ack_r;
   assign o_wb_dat = rdat_r;
   ////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_ocp_last;
      run && cyc_end && ocp_any && ocp_cnt_r == 3'h4;
   endsequence
   sequence s_latched_off;
      state_r == rps_pkg::RPS_PROT_LATCH && o_boost_pulldown && !o_hs_gate && !o_ls_gate;
   endsequence
   property p_cmr_cut;
      o_hs_gate && zc_s |=> !o_hs_gate [*2];
   endproperty
   a_cmr_cut: assert property (p_cmr_cut) else $error("gate not cut near zero");
   property p_cmr_noprot;
      run && zc_s && !ocp_s && !otp_s && !opp_hit && !cyc_end |=> run;
   endproperty
   a_cmr_noprot: assert property (p_cmr_noprot) else $error("cmr stopped run");
   property p_ocp_cut;
      o_ls_gate && ocp_s |=> !o_ls_gate;
   endproperty
   a_ocp_cut: assert property (p_ocp_cut) else $error("overcurrent not cut");
   property p_ocp_latch;
      s_ocp_last |=> s_latched_off;
   endproperty
   a_ocp_latch: assert property (p_ocp_latch) else $error("no ocp latch");
   property p_otp;
      run && otp_s |=> s_latched_off;
   endproperty
   a_otp: assert property (p_otp) else $error("no otp latch");
   property p_opp_end;
      run && !otp_s && !(cyc_end && ocp_any) && opp_hit |=>
         (set1_r.latched ? state_r == rps_pkg::RPS_PROT_LATCH
                         : state_r == rps_pkg::RPS_PROT_RESTART);
   endproperty
   a_opp_end: assert property (p_opp_end) else $error("overpower action wrong");
   property p_clamp;
      ##1 o_swing_lim <= (set1_r.cap200 ? P_LIM200 : P_LIM150) || $changed(set1_r);
   endproperty
   a_clamp: assert property (p_clamp) else $error("swing above limit");
   property p_inf;
      set1_r.opp_inf && run |=> opp_cnt_r == 11'h0;
   endproperty
   a_inf: assert property (p_inf) else $error("disabled timer counts");
   property p_nostart;
      state_r == rps_pkg::RPS_NOSTART |=> state_r == rps_pkg::RPS_NOSTART && !o_hs_gate;
   endproperty
   a_nostart: assert property (p_nostart) else $error("start with shorted pin");
   property p_pg_wait;
      state_r == rps_pkg::RPS_WAIT_BOOST |-> o_pg_out && o_pg_oe && !o_hs_gate;
   endproperty
   a_pg_wait: assert property (p_pg_wait) else $error("pg pin not high before run");
   property p_pg_boost;
      run && $past(run) && !bdet_s |=> o_pg_out || !run;
   endproperty
   a_pg_boost: assert property (p_pg_boost) else $error("pg not raised");
   property p_prot_pin;
      state_r == rps_pkg::RPS_PROT_LATCH |-> !o_pg_out && !o_hs_gate && !o_ls_gate;
   endproperty
   a_prot_pin: assert property (p_prot_pin) else $error("protection pin high");
   property p_latch_hold;
      state_r == rps_pkg::RPS_PROT_LATCH && !mains_s |=> state_r == rps_pkg::RPS_PROT_LATCH;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch released");
endmodule : rps_ctrl

// file: tb/rps_stage_model.sv
// companion boost converter as seen through the boost sense pin
// assumes the controller pull-down input and bench-side voltage wishes
module rps_stage_model (
   input  wire logic i_clk,      // system clock
   input  wire logic i_pulldown, // controller pulls boost pin low
   input  wire logic i_up,       // boost voltage present
   input  wire logic i_ok,       // boost voltage above detect level
   output logic      o_start,    // boost sense above start level
   output logic      o_det       // boost sense above detect level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] rise_r;           // companion waits before its output rises
   ////////////////////////////////////////////////////////////////////////
   // pulled-low pin shuts the companion and its voltage collapses
   always_ff @(posedge i_clk) begin
      rise_r  <= {rise_r[0], i_up & ~i_pulldown};
      o_start <= rise_r[1] & ~i_pulldown;
      o_det   <= rise_r[1] & i_ok & ~i_pulldown;
   end
endmodule : rps_stage_model

// file: tb/tb_top.sv
// self-checking bench of the protection and settings controller
// assumes rps_ctrl with a 20-cycle ms tick and the companion model
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk, i_nrst, req, i_wb_we, o_wb_ack, i_hs_req, i_ls_req, i_cur_near_zero;
   logic i_ocp, i_otp, i_opp_over, i_boost_start, i_boost_det, i_mains_reset, i_meas_done;
   logic o_hs_gate, o_ls_gate, o_boost_pulldown, o_pg_out, o_pg_oe, o_opp_lvl175, up, ok;
   logic [3:0]  i_wb_adr, i_set1_code;
   logic [31:0] i_wb_dat, o_wb_dat, d;
   logic [11:0] i_swing_cmd, o_swing_lim;
   logic [2:0]  i_set2_code;
   logic [1:0]  i_bfreq_code, o_burst_freq, o_hp_lp_level;
   logic [7:0]  o_burst_level, lf;
   int          checks, n_mismatch;
   // burst entry levels in half percent, indexed by second code and frequency
   logic [7:0]  blv [32] = '{8'h12, 8'h12, 8'h12, 8'h12, 8'h18, 8'h18, 8'h18, 8'h18,
      8'h12, 8'h12, 8'h12, 8'h14, 8'h18, 8'h18, 8'h18, 8'h1a, 8'h12, 8'h14, 8'h16, 8'h18,
      8'h18, 8'h1a, 8'h1e, 8'h22, 8'h12, 8'h14, 8'h18, 8'h1c, 8'h18, 8'h1e, 8'h23, 8'h28};
   rps_ctrl #(.P_CYC_PER_MS(20)) i_rps_ctrl (.i_sys_clk, .i_nrst, .i_wb_cyc(req),
      .i_wb_stb(req), .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel(4'h1), .o_wb_dat, .o_wb_ack,
      .i_hs_req, .i_ls_req, .i_swing_cmd, .i_cur_near_zero, .i_ocp, .i_otp, .i_opp_over,
      .i_boost_start, .i_boost_det, .i_mains_reset, .i_meas_done, .i_set1_code,
      .i_set2_code, .i_bfreq_code, .o_hs_gate, .o_ls_gate, .o_boost_pulldown, .o_pg_out,
      .o_pg_oe, .o_swing_lim, .o_burst_freq, .o_hp_lp_level, .o_burst_level, .o_opp_lvl175);
   rps_stage_model i_rps_stage_model (.i_clk(i_sys_clk), .i_pulldown(o_boost_pulldown),
      .i_up(up), .i_ok(ok), .o_start(i_boost_start), .o_det(i_boost_det));
   ////////////////////////////////////////////////////////////////////////
   // expectation helpers and bus, compare and sequencing tasks
   function automatic logic [7:0] nxt(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : nxt
   function automatic logic [11:0] f_lim(input logic [11:0] c);
      return (c > 12'h800) ? 12'h800 : c;
   endfunction : f_lim
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : cyc
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] wd);
      @(posedge i_sys_clk);
      chk("ack idle", 32'h0, {31'h0, o_wb_ack});
      req      <= 1'h1;
      i_wb_we  <= we;
      i_wb_adr <= a;
      i_wb_dat <= wd;
      do @(posedge i_sys_clk); while (o_wb_ack !== 1'h1);
      d = o_wb_dat;
      req <= 1'h0;
   endtask : wb
   task automatic st(input logic [2:0] e);
      wb(1'h0, 4'h4, 32'h0);
      chk("state", {29'h0, e}, {29'h0, d[2:0]});
   endtask : st
   task automatic rst(input logic [3:0] c);
      i_set1_code <= c;
      i_nrst      <= 1'h0;
      cyc(5);
      chk("reset pins", 32'h2, {o_boost_pulldown, o_pg_oe});
      i_nrst <= 1'h1;
      cyc(20);
   endtask : rst
   task automatic sw(input logic o);
      i_ls_req <= 1'h1;
      i_ocp    <= o;
      cyc(3);
      i_ocp <= 1'h0;
      cyc(3);
      i_ls_req <= 1'h0;
      cyc(4);
   endtask : sw
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////
   // clock, watchdog and main sequence
   initial begin
      i_sys_clk = 1'h0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      #400us;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      {req, i_wb_we, i_hs_req, i_ls_req, i_cur_near_zero, i_ocp, i_otp} = '0;
      {i_opp_over, i_mains_reset, i_wb_adr, i_wb_dat, i_swing_cmd} = '0;
      {i_nrst, i_meas_done, up, ok, lf} = {4'hf, 8'h1c};
      i_set2_code = lf[2:0];
      i_bfreq_code = lf[4:3];
      rst(4'h0);
      i_hs_req <= 1'h1;
      st(3'h6);
      chk("nostart gate", 32'h0, {31'h0, o_hs_gate});
      $display("test nostart done");
      i_hs_req <= 1'h0;
      rst(4'h3);
      wb(1'h1, 4'h0, 32'h1);
      wb(1'h0, 4'h0, 32'h0);
      chk("ctrl", 32'h1, {31'h0, d[0]});
      wb(1'h0, 4'h8, 32'h0);
      chk("set1 decode", 32'h18, {27'h0, d[12:8]});
      chk("bfreq", {30'h0, i_bfreq_code}, {30'h0, o_burst_freq});
      chk("hp level", {30'h0, i_set2_code[2:1]}, {30'h0, o_hp_lp_level});
      chk("burst lvl", blv[{i_set2_code, i_bfreq_code}], o_burst_level);
      chk("lvl175", 32'h1, {31'h0, o_opp_lvl175});
      cyc(20);
      st(3'h3);
      chk("pg run", 32'h1, {o_pg_out, o_pg_oe});
      for (int k = 0; k < 6; k++) begin
         lf = nxt(lf);
         i_swing_cmd <= {lf, lf[3:0]};
         cyc(3);
         chk("clamp", f_lim({lf, lf[3:0]}), o_swing_lim);
      end
      i_hs_req <= 1'h1;
      cyc(3);
      chk("hs on", 32'h1, {31'h0, o_hs_gate});
      i_cur_near_zero <= 1'h1;
      cyc(1);
      i_cur_near_zero <= 1'h0;
      cyc(5);
      chk("hs cut", 32'h0, {31'h0, o_hs_gate});
      st(3'h3);
      i_hs_req <= 1'h0;
      ok <= 1'h0;
      cyc(6);
      chk("pg boost", 32'h1, {31'h0, o_pg_out});
      ok <= 1'h1;
      cyc(6);
      $display("test run done");
      repeat (4) sw(1'h1);
      sw(1'h0);
      wb(1'h0, 4'h4, 32'h0);
      chk("ocp count", 32'h3, {26'h0, d[9:7], d[2:0]});
      repeat (5) sw(1'h1);
      st(3'h4);
      chk("ocp pins", 32'h2, {o_ls_gate, o_boost_pulldown, o_pg_out});
      i_mains_reset <= 1'h1;
      cyc(4);
      i_mains_reset <= 1'h0;
      cyc(30);
      st(3'h3);
      $display("test ocp done");
      i_opp_over <= 1'h1;
      cyc(600);
      i_opp_over <= 1'h0;
      cyc(5);
      wb(1'h0, 4'hc, 32'h0);
      chk("opp clear", 32'h0, {21'h0, d[10:0]});
      i_opp_over <= 1'h1;
      cyc(880);
      chk("pg early", 32'h0, {31'h0, o_pg_out});
      cyc(40);
      chk("pg end", 32'h1, {31'h0, o_pg_out});
      cyc(100);
      i_opp_over <= 1'h0;
      st(3'h5);
      cyc(20050);
      st(3'h3);
      $display("test opp done");
      i_otp <= 1'h1;
      cyc(6);
      st(3'h4);
      chk("otp pins", 32'h2, {o_hs_gate, o_boost_pulldown, o_pg_out});
      i_otp <= 1'h0;
      rst(4'h1);
      i_opp_over <= 1'h1;
      cyc(4400);
      st(3'h3);
      chk("pg inf", 32'h0, {31'h0, o_pg_out});
      $display("test infinite done");
      end_of_test();
   end
endmodule : tb_top
